// ===== design/mrc_pkg.sv
// Purpose: Constants and types for the management mode restart control block.
// Assumes: Offsets are relative to the management base address; one 32-bit word per access.
// Notes:   Behaviour summary follows.
package mrc_pkg;

  // ---------------------------------------------------------------
  // Save area layout
  // ---------------------------------------------------------------
  localparam logic [15:0] SAVE_AREA_LO     = 16'hfe00;
  localparam int          SAVE_AREA_BYTES  = 512;
  localparam logic [15:0] OFF_IO_RESTART   = 16'hff00;
  localparam logic [15:0] OFF_HALT_RESTART = 16'hff02;
  localparam logic [15:0] OFF_IO_TRAP      = 16'hffa4;
  localparam logic [15:0] OFF_DBG_CTL      = 16'hffc8;
  localparam logic [15:0] OFF_DBG_STAT     = 16'hffcc;

  // ---------------------------------------------------------------
  // Field positions and values
  // ---------------------------------------------------------------
  localparam int          HALT_FROM_BIT    = 0;
  localparam int          TRAP_DIR_BIT     = 0;
  localparam int          TRAP_VALID_BIT   = 1;
  localparam int          TRAP_STRING_BIT  = 2;
  localparam int          TRAP_REP_BIT     = 3;
  localparam int          TRAP_PORT_LSB    = 16;
  localparam logic [15:0] RESTART_CONTINUE = 16'h0000;
  localparam logic [15:0] RESTART_REEXEC   = 16'h00ff;
  localparam logic [31:0] DBG_CTL_RESET    = 32'h0000_0000;
  localparam logic [31:0] DBG_STAT_RESET   = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam logic [1:0]  TRAP_LEAD_EDGES  = 2'd3;

  typedef enum logic [1:0] {
    MRC_IDLE,
    MRC_SAVE,
    MRC_IN_MODE,
    MRC_RESUME
  } mrc_state_t;

endpackage

// ===== design/mrc_io_trap_qual.sv
// Purpose: Decides whether a management interrupt guarantees an I/O instruction trap.
// Assumes: All inputs are synchronous to clk.
// Notes:   Only the guaranteed case is trapped; later arrivals wait for the boundary.
`timescale 1ns/1ps
module mrc_io_trap_qual
  import mrc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Bus cycle observation
  input  wire logic io_cycle,
  input  wire logic mgmt_interrupt_n,
  input  wire logic burst_ready_n,
  // Result
  output logic      trap_hit
);

  logic [1:0] lead_r;

  // -----------------------------------------------------------------
  // Edge counter since the interrupt was first seen in this cycle
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lead_r <= 2'd0;
    end else if (!io_cycle || !burst_ready_n) begin
      lead_r <= 2'd0;
    end else if (lead_r != 2'd0 && lead_r != TRAP_LEAD_EDGES) begin
      lead_r <= lead_r + 2'd1;
    end else if (lead_r == 2'd0 && !mgmt_interrupt_n) begin
      lead_r <= 2'd1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trap_hit <= 1'b0;
    end else begin
      trap_hit <= io_cycle && !burst_ready_n && (lead_r == TRAP_LEAD_EDGES);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_trap_lead;
    (io_cycle && burst_ready_n && !mgmt_interrupt_n && lead_r == 2'd0)
      ##1 (io_cycle && burst_ready_n) [*2] ##1 (io_cycle && !burst_ready_n) |=> trap_hit;
  endproperty
  a_trap_lead: assert property (p_trap_lead) else $error("qualified interrupt did not trap");

endmodule

// ===== design/mrc_restart_ctrl.sv
// Purpose: Entry context capture, resume decisions and event priority for management mode.
// Assumes: Handler reaches the save slots over the slot access port, offsets relative to mgmt_base.
// Notes:   Word at the restart offset holds the restart slot low and the halt slot high.
`timescale 1ns/1ps
module mrc_restart_ctrl
  import mrc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Management interrupt and bus observation
  input  wire logic        mgmt_interrupt_n,
  input  wire logic        cache_flush_n,
  input  wire logic        io_cycle,
  input  wire logic        burst_ready_n,
  // Current instruction context
  input  wire logic        instr_boundary,
  input  wire logic        core_halted,
  input  wire logic [15:0] io_port_addr,
  input  wire logic        io_is_input,
  input  wire logic        io_is_string,
  input  wire logic        io_has_repeat,
  input  wire logic        io_reexec_done,
  // Debug and NMI
  input  wire logic        debug_trap_req,
  input  wire logic [31:0] dbg_ctl_in,
  input  wire logic [31:0] dbg_stat_in,
  input  wire logic        nmi_req,
  input  wire logic        nmi_masked_in,
  // Instruction events inside the mode
  input  wire logic        mode_resume_instr,
  input  wire logic        interrupt_return_instr,
  // Save slot access
  input  wire logic [31:0] mgmt_base,
  input  wire logic        slot_rd,
  input  wire logic        slot_wr,
  input  wire logic [31:0] slot_addr,
  input  wire logic [3:0]  slot_be,
  input  wire logic [31:0] slot_wdata,
  output logic [31:0]      slot_rdata,
  output logic             slot_ack,
  // Mode and resume outcome
  output logic             system_management_mode,
  output logic             resume_to_halt,
  output logic             halt_bus_cycle,
  output logic             resume_next,
  output logic             io_reexec,
  // Prioritised events
  output logic             flush_take,
  output logic             debug_take,
  output logic             nmi_take,
  output logic             nmi_masked,
  // Debug register restore
  output logic             dbg_restore,
  output logic [31:0]      dbg_ctl_out,
  output logic [31:0]      dbg_stat_out
);

  mrc_state_t  st_r;
  logic        smi_prev_r;
  logic        smi_pend_r;
  logic        trap_hit;
  logic        trap_pend_r;
  logic [31:0] trap_info_r;
  logic [31:0] trap_dword_r;
  logic [15:0] restart_slot_r;
  logic        halt_slot_r;
  logic        reexec_pend_r;
  logic        dbg_defer_r;
  logic        dbg_wait_reexec_r;
  logic        nmi_en_r;
  logic        nmi_saved_r;
  logic [31:0] dbg_ctl_r;
  logic [31:0] dbg_stat_r;
  logic [15:0] offset;
  logic        in_area;
  logic        io_trap_now;
  logic        go_entry;
  logic        debug_normal;

  // -----------------------------------------------------------------
  // Guaranteed I/O trap detection
  // -----------------------------------------------------------------
  mrc_io_trap_qual u_qual (
    .clk              (clk),
    .reset            (reset),
    .io_cycle         (io_cycle),
    .mgmt_interrupt_n (mgmt_interrupt_n),
    .burst_ready_n    (burst_ready_n),
    .trap_hit         (trap_hit)
  );

  // -----------------------------------------------------------------
  // Entry decision and priority
  // -----------------------------------------------------------------
  // During an I/O trap the interrupt and flush sampling outrank debug traps.
  assign io_trap_now  = trap_hit || trap_pend_r;
  assign debug_normal = instr_boundary && debug_trap_req && !io_trap_now && !dbg_defer_r;
  assign go_entry     = (st_r == MRC_IDLE) && (io_trap_now || (smi_pend_r && instr_boundary && !debug_normal));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      smi_prev_r <= 1'b1;
      smi_pend_r <= 1'b0;
    end else begin
      smi_prev_r <= mgmt_interrupt_n;
      // A new falling edge wins over the clear taken at entry.
      if (smi_prev_r && !mgmt_interrupt_n) begin
        smi_pend_r <= 1'b1;
      end else if (st_r == MRC_SAVE) begin
        smi_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trap_pend_r <= 1'b0;
      trap_info_r <= 32'h0000_0000;
    end else if (trap_hit) begin
      // Held until the save state copies it, also when entry starts on this very edge.
      trap_pend_r <= 1'b1;
      trap_info_r <= {io_port_addr, 12'h000, io_has_repeat, io_is_string, 1'b1, io_is_input};
    end else if (st_r == MRC_SAVE) begin
      trap_pend_r <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Mode state machine
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= MRC_IDLE;
    end else begin
      case (st_r)
        MRC_IDLE: begin
          if (go_entry) begin
            st_r <= MRC_SAVE;
          end
        end
        MRC_SAVE: begin
          st_r <= MRC_IN_MODE;
        end
        MRC_IN_MODE: begin
          if (mode_resume_instr) begin
            st_r <= MRC_RESUME;
          end
        end
        MRC_RESUME: begin
          // A second interrupt is serviced before any pending re-execution.
          st_r <= smi_pend_r ? MRC_SAVE : MRC_IDLE;
        end
        default: begin
          st_r <= MRC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      system_management_mode <= 1'b0;
    end else if (go_entry) begin
      system_management_mode <= 1'b1;
    end else if (st_r == MRC_RESUME && !smi_pend_r) begin
      system_management_mode <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Save slots: entry capture and handler writes
  // -----------------------------------------------------------------
  assign offset  = 16'(slot_addr - mgmt_base);
  assign in_area = (slot_addr - mgmt_base) < 32'h0001_0000 && offset >= SAVE_AREA_LO;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      halt_slot_r    <= 1'b0;
      restart_slot_r <= RESTART_CONTINUE;
      trap_dword_r   <= 32'h0000_0000;
    end else if (st_r == MRC_SAVE) begin
      halt_slot_r    <= core_halted;
      restart_slot_r <= RESTART_CONTINUE;
      // Nested entry while a re-execution waits never reports a valid trap.
      if (trap_pend_r && !reexec_pend_r) begin
        trap_dword_r <= trap_info_r;
      end else begin
        trap_dword_r <= {trap_info_r[31:TRAP_VALID_BIT+1], 1'b0, trap_info_r[TRAP_DIR_BIT]};
      end
    end else if (st_r == MRC_IN_MODE && slot_wr && in_area && offset == OFF_IO_RESTART) begin
      if (slot_be[0]) begin
        restart_slot_r[7:0] <= slot_wdata[7:0];
      end
      if (slot_be[1]) begin
        restart_slot_r[15:8] <= slot_wdata[15:8];
      end
      if (slot_be[2]) begin
        halt_slot_r <= slot_wdata[16+HALT_FROM_BIT];
      end
    end
  end

  // The handler owns these copies while in the mode; exit puts them back.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dbg_ctl_r  <= DBG_CTL_RESET;
      dbg_stat_r <= DBG_STAT_RESET;
    end else if (go_entry) begin
      // Only a first entry captures; a nested entry keeps the outer copies.
      dbg_ctl_r  <= dbg_ctl_in;
      dbg_stat_r <= dbg_stat_in;
    end else if (st_r == MRC_IN_MODE && slot_wr && in_area && slot_be == 4'hf) begin
      if (offset == OFF_DBG_CTL) begin
        dbg_ctl_r <= slot_wdata;
      end
      if (offset == OFF_DBG_STAT) begin
        dbg_stat_r <= slot_wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      slot_rdata <= 32'h0000_0000;
      slot_ack   <= 1'b0;
    end else begin
      slot_ack <= slot_rd || slot_wr;
      if (slot_rd && in_area) begin
        case (offset)
          OFF_IO_RESTART: slot_rdata <= {15'h0000, halt_slot_r, restart_slot_r};
          OFF_IO_TRAP:    slot_rdata <= trap_dword_r;
          OFF_DBG_CTL:    slot_rdata <= dbg_ctl_r;
          OFF_DBG_STAT:   slot_rdata <= dbg_stat_r;
          default:        slot_rdata <= 32'h0000_0000;
        endcase
      end else if (slot_rd) begin
        slot_rdata <= 32'h0000_0000;
      end
    end
  end

  // -----------------------------------------------------------------
  // Resume outcome
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      resume_to_halt <= 1'b0;
      halt_bus_cycle <= 1'b0;
      resume_next    <= 1'b0;
      io_reexec      <= 1'b0;
      dbg_restore    <= 1'b0;
      dbg_ctl_out    <= DBG_CTL_RESET;
      dbg_stat_out   <= DBG_STAT_RESET;
    end else begin
      resume_to_halt <= 1'b0;
      halt_bus_cycle <= 1'b0;
      resume_next    <= 1'b0;
      io_reexec      <= 1'b0;
      dbg_restore    <= 1'b0;
      if (st_r == MRC_RESUME && !smi_pend_r) begin
        dbg_restore  <= 1'b1;
        dbg_ctl_out  <= dbg_ctl_r;
        dbg_stat_out <= dbg_stat_r;
        // Halt is re-entered without running the halt instruction again.
        if (halt_slot_r) begin
          resume_to_halt <= 1'b1;
          halt_bus_cycle <= 1'b1;
        end else if (reexec_pend_r || restart_slot_r == RESTART_REEXEC) begin
          io_reexec <= 1'b1;
        end else begin
          resume_next <= 1'b1;
        end
      end
    end
  end

  // A re-execution request survives a nested entry and its cleared slot.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reexec_pend_r <= 1'b0;
    end else if (st_r == MRC_RESUME && smi_pend_r && restart_slot_r == RESTART_REEXEC) begin
      reexec_pend_r <= 1'b1;
    end else if (st_r == MRC_RESUME && !smi_pend_r) begin
      reexec_pend_r <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Debug trap deferral and flush sampling
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dbg_defer_r       <= 1'b0;
      dbg_wait_reexec_r <= 1'b0;
      debug_take        <= 1'b0;
      flush_take        <= 1'b0;
    end else begin
      debug_take <= 1'b0;
      flush_take <= (st_r == MRC_IDLE) && instr_boundary && !cache_flush_n && !debug_normal;
      if (go_entry && io_trap_now && debug_trap_req) begin
        dbg_defer_r <= 1'b1;
      end else if (st_r == MRC_RESUME && !smi_pend_r && dbg_defer_r) begin
        if (!halt_slot_r && (reexec_pend_r || restart_slot_r == RESTART_REEXEC)) begin
          dbg_wait_reexec_r <= 1'b1;
        end else begin
          debug_take <= 1'b1;
        end
        dbg_defer_r <= 1'b0;
      end else if (dbg_wait_reexec_r && io_reexec_done) begin
        debug_take        <= 1'b1;
        dbg_wait_reexec_r <= 1'b0;
      end else if (debug_normal && st_r == MRC_IDLE && !dbg_wait_reexec_r) begin
        debug_take <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // NMI gating
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      nmi_en_r    <= 1'b0;
      nmi_saved_r <= 1'b0;
      nmi_masked  <= 1'b0;
      nmi_take    <= 1'b0;
    end else begin
      if (go_entry) begin
        nmi_saved_r <= nmi_masked_in;
        nmi_en_r    <= 1'b0;
        nmi_masked  <= 1'b1;
      end else if (st_r == MRC_RESUME && !smi_pend_r) begin
        nmi_masked <= nmi_saved_r;
        nmi_en_r   <= 1'b0;
      end else if (system_management_mode && interrupt_return_instr) begin
        nmi_en_r   <= 1'b1;
        nmi_masked <= 1'b0;
      end
      nmi_take <= nmi_req && (system_management_mode ? nmi_en_r : !nmi_masked_in);
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_halt_saved;
    (st_r == MRC_SAVE) |=> (halt_slot_r == $past(core_halted));
  endproperty
  a_halt_saved: assert property (p_halt_saved) else $error("halt slot not captured");

  property p_restart_init;
    (st_r == MRC_SAVE) |=> (restart_slot_r == RESTART_CONTINUE) && (st_r == MRC_IN_MODE);
  endproperty
  a_restart_init: assert property (p_restart_init) else $error("restart slot not cleared");

  property p_nested_invalid;
    (st_r == MRC_SAVE && reexec_pend_r) |=> !trap_dword_r[TRAP_VALID_BIT];
  endproperty
  a_nested_invalid: assert property (p_nested_invalid) else $error("nested entry set valid");

  property p_halt_resume;
    (st_r == MRC_RESUME && !smi_pend_r && halt_slot_r) |=> halt_bus_cycle && resume_to_halt && !io_reexec;
  endproperty
  a_halt_resume: assert property (p_halt_resume) else $error("halt resume missing bus cycle");

  property p_reexec;
    (st_r == MRC_RESUME && !smi_pend_r && !halt_slot_r && restart_slot_r == RESTART_REEXEC)
      |=> io_reexec && !resume_next;
  endproperty
  a_reexec: assert property (p_reexec) else $error("re-execution not requested");

  property p_debug_after_reexec;
    dbg_wait_reexec_r && !io_reexec_done |=> !debug_take;
  endproperty
  a_debug_after_reexec: assert property (p_debug_after_reexec) else $error("debug trap too early");

  property p_debug_deferred;
    dbg_defer_r && system_management_mode |-> !debug_take;
  endproperty
  a_debug_deferred: assert property (p_debug_deferred) else $error("debug trap inside mode");

  property p_nmi_blocked;
    (st_r == MRC_SAVE) ##1 (!interrupt_return_instr && st_r == MRC_IN_MODE) |=> !nmi_take;
  endproperty
  a_nmi_blocked: assert property (p_nmi_blocked) else $error("NMI before interrupt return");

  property p_nmi_restore;
    (st_r == MRC_RESUME && !smi_pend_r) |=> (nmi_masked == $past(nmi_saved_r)) && !system_management_mode;
  endproperty
  a_nmi_restore: assert property (p_nmi_restore) else $error("NMI mask not restored");

endmodule

// ===== verification/mrc_sys_logic.sv
// Purpose: System logic model that raises the management interrupt on request.
// Assumes: Requests come only while the block is out of the mode.
// Notes:   The line stays low until the mode is seen, so no request is lost.
`timescale 1ns/1ps
module mrc_sys_logic (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Request and acknowledge
  input  wire logic fire,
  input  wire logic in_mode,
  // Interrupt line
  output logic      mgmt_interrupt_n
);
  // ---------------------------------------------------------------
  // Interrupt level
  // ---------------------------------------------------------------
  // Release on entry gives a clean falling edge for the next request.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mgmt_interrupt_n <= 1'b1;
    end else if (fire) begin
      mgmt_interrupt_n <= 1'b0;
    end else if (in_mode) begin
      mgmt_interrupt_n <= 1'b1;
    end
  end
endmodule

// ===== verification/test_mrc_restart_ctrl.sv
// Purpose: Self-checking bench for entry capture, slot access and resume outcomes.
// Assumes: Inputs change 2 ns after the rising edge, outputs are read there too.
// Notes:   Entries from halt, from a trapped I/O cycle and from a plain boundary.
`timescale 1ns/1ps
module test_mrc_restart_ctrl;
  import mrc_pkg::*;
  logic        clk, reset, fire, mgmt_interrupt_n, cache_flush_n, io_cycle, burst_ready_n;
  logic        instr_boundary, core_halted, io_is_input, io_is_string, io_has_repeat, io_reexec_done;
  logic        debug_trap_req, nmi_req, nmi_masked_in, mode_resume_instr, interrupt_return_instr;
  logic        slot_rd, slot_wr, slot_ack, system_management_mode, resume_to_halt, halt_bus_cycle;
  logic        resume_next, io_reexec, flush_take, debug_take, nmi_take, nmi_masked, dbg_restore;
  logic [15:0] io_port_addr;
  logic [3:0]  slot_be;
  logic [31:0] dbg_ctl_in, dbg_stat_in, mgmt_base, slot_addr, slot_wdata, slot_rdata;
  logic [31:0] dbg_ctl_out, dbg_stat_out, rd, exp_w;
  int          errors, checks, seed, k;

  mrc_sys_logic u_sys (.clk(clk), .reset(reset), .fire(fire), .in_mode(system_management_mode),
    .mgmt_interrupt_n(mgmt_interrupt_n));
  mrc_restart_ctrl u_dut (.clk(clk), .reset(reset), .mgmt_interrupt_n(mgmt_interrupt_n),
    .cache_flush_n(cache_flush_n), .io_cycle(io_cycle), .burst_ready_n(burst_ready_n),
    .instr_boundary(instr_boundary), .core_halted(core_halted), .io_port_addr(io_port_addr),
    .io_is_input(io_is_input), .io_is_string(io_is_string), .io_has_repeat(io_has_repeat),
    .io_reexec_done(io_reexec_done), .debug_trap_req(debug_trap_req), .dbg_ctl_in(dbg_ctl_in),
    .dbg_stat_in(dbg_stat_in), .nmi_req(nmi_req), .nmi_masked_in(nmi_masked_in),
    .mode_resume_instr(mode_resume_instr), .interrupt_return_instr(interrupt_return_instr),
    .mgmt_base(mgmt_base), .slot_rd(slot_rd), .slot_wr(slot_wr), .slot_addr(slot_addr),
    .slot_be(slot_be), .slot_wdata(slot_wdata), .slot_rdata(slot_rdata), .slot_ack(slot_ack),
    .system_management_mode(system_management_mode), .resume_to_halt(resume_to_halt),
    .halt_bus_cycle(halt_bus_cycle), .resume_next(resume_next), .io_reexec(io_reexec),
    .flush_take(flush_take), .debug_take(debug_take), .nmi_take(nmi_take), .nmi_masked(nmi_masked),
    .dbg_restore(dbg_restore), .dbg_ctl_out(dbg_ctl_out), .dbg_stat_out(dbg_stat_out));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk_w(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (exp !== got) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_b(input string name, input logic exp, input logic got);
    chk_w(name, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic acc(input logic wr, input logic [15:0] off, input logic [3:0] be, input logic [31:0] wd);
    slot_wr = wr;
    slot_rd = !wr;
    slot_addr = mgmt_base + {16'h0000, off};
    slot_be = be;
    slot_wdata = wd;
    step(1);
    slot_rd = 1'b0;
    slot_wr = 1'b0;
    chk_b("slot_ack", 1'b1, slot_ack);
    rd = slot_rdata;
    step(1);
  endtask

  task automatic wait_mode(input logic lvl);
    int i;
    for (i = 0; i < 30 && system_management_mode !== lvl; i++) step(1);
    chk_b("mode", lvl, system_management_mode);
  endtask

  task automatic resume(input logic halt_e, input logic reex_e, input logic next_e);
    int i;
    mode_resume_instr = 1'b1;
    step(1);
    mode_resume_instr = 1'b0;
    for (i = 0; i < 8 && resume_to_halt !== 1'b1 && io_reexec !== 1'b1 && resume_next !== 1'b1; i++) step(1);
    chk_b("resume_to_halt", halt_e, resume_to_halt);
    chk_b("halt_bus_cycle", halt_e, halt_bus_cycle);
    chk_b("io_reexec", reex_e, io_reexec);
    chk_b("resume_next", next_e, resume_next);
    chk_b("dbg_restore", 1'b1, dbg_restore);
    chk_w("dbg_ctl_out", dbg_ctl_in, dbg_ctl_out);
    chk_w("dbg_stat_out", dbg_stat_in, dbg_stat_out);
    chk_b("mode_exit", 1'b0, system_management_mode);
  endtask

  task automatic summarize();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog and scenarios
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200000;
    errors++;
    summarize();
  end

  initial begin
    errors = 0; checks = 0; seed = 44091;
    reset = 1'b1; fire = 1'b0; cache_flush_n = 1'b1; io_cycle = 1'b0; burst_ready_n = 1'b1;
    instr_boundary = 1'b0; core_halted = 1'b0; io_port_addr = 16'h0000; io_is_input = 1'b0;
    io_is_string = 1'b0; io_has_repeat = 1'b0; io_reexec_done = 1'b0; debug_trap_req = 1'b0;
    nmi_req = 1'b0; nmi_masked_in = 1'b0; mode_resume_instr = 1'b0; interrupt_return_instr = 1'b0;
    slot_rd = 1'b0; slot_wr = 1'b0; slot_be = 4'h0; slot_wdata = 32'h0; slot_addr = 32'h0;
    mgmt_base = 32'h0003_0000; dbg_ctl_in = $random(seed); dbg_stat_in = $random(seed);
    step(12);
    reset = 1'b0;
    step(2);
    // Halt entry, trapped I/O cycle at the exact three-edge lead, then plain boundary entry.
    for (k = 0; k < 3; k++) begin
      io_port_addr = $random(seed);
      {io_is_input, io_is_string, io_has_repeat} = $random(seed);
      core_halted = (k == 0);
      nmi_masked_in = (k == 1);
      io_cycle = (k == 1);
      instr_boundary = (k != 1);
      fire = 1'b1;
      step(1);
      fire = 1'b0;
      if (k == 1) begin
        step(3);
        burst_ready_n = 1'b0;
        step(1);
        burst_ready_n = 1'b1;
        io_cycle = 1'b0;
      end
      wait_mode(1'b1);
      instr_boundary = 1'b0;
      step(2);
      acc(1'b0, OFF_IO_RESTART, 4'hf, 32'h0);
      chk_w("restart_word", {15'h0, k == 0, RESTART_CONTINUE}, rd);
      acc(1'b0, OFF_IO_TRAP, 4'hf, 32'h0);
      chk_b("trap_valid", k == 1, rd[TRAP_VALID_BIT]);
      exp_w = {io_port_addr, 12'h000, io_has_repeat, io_is_string, 1'b1, io_is_input};
      if (k == 1) chk_w("trap_dword", exp_w, rd);
      if (rd[TRAP_VALID_BIT] === 1'b1) acc(1'b1, OFF_IO_RESTART, 4'h3, {16'h0, RESTART_REEXEC});
      if (k == 2) begin
        acc(1'b1, OFF_IO_RESTART, 4'h7, 32'h0);
        acc(1'b0, 16'hffa0, 4'hf, 32'h0);
        chk_w("unmapped", 32'h0, rd);
        nmi_req = 1'b1;
        step(1);
        chk_b("nmi_before_interrupt_return_instr", 1'b0, nmi_take);
        interrupt_return_instr = 1'b1;
        step(1);
        interrupt_return_instr = 1'b0;
        step(1);
        chk_b("nmi_after_interrupt_return_instr", 1'b1, nmi_take);
        nmi_req = 1'b0;
      end
      resume(k == 0, k == 1, k == 2);
      chk_b("nmi_masked", k == 1, nmi_masked);
      if (k == 1) begin
        io_reexec_done = 1'b1;
        step(1);
        io_reexec_done = 1'b0;
      end
      step(3);
    end
    // Flush sampling alone, then a normal debug trap that outranks it.
    instr_boundary = 1'b1;
    cache_flush_n = 1'b0;
    step(1);
    chk_b("flush_take", 1'b1, flush_take);
    debug_trap_req = 1'b1;
    step(1);
    chk_b("flush_blocked", 1'b0, flush_take);
    chk_b("debug_take", 1'b1, debug_take);
    instr_boundary = 1'b0;
    cache_flush_n = 1'b1;
    debug_trap_req = 1'b0;
    step(2);
    summarize();
  end
endmodule
